// *** pdw_core_model.sv ***
// Core, reset pin and wake source model
`timescale 1ns/1ps
module pdw_core_model (
  input wire logic clk_i,
  input wire logic pin_oe_i,
  output logic halt_o,
  output logic clr_o,
  output logic ovf_o,
  output logic ext_o,
  output logic [7:0] port_o,
  output logic irq_o,
  output logic irq_en_o,
  output logic full_o,
  output logic pin_o
);
  initial {halt_o, clr_o, ovf_o, ext_o, port_o, irq_o, irq_en_o, full_o} = 15'h07F8;
  assign pin_o = pin_oe_i ? 1'b0 : 1'b1; // Pull-up on open drain
  task automatic pulse(input int s);
    @(posedge clk_i);
    case (s)
      0: halt_o <= 1'b1;
      1: clr_o <= 1'b1;
      2: ovf_o <= 1'b1;
      default: ext_o <= 1'b1;
    endcase
    @(posedge clk_i);
    {halt_o, clr_o, ovf_o, ext_o} <= 4'h0;
    @(posedge clk_i);
  endtask : pulse
  task automatic fall(input int p);
    @(posedge clk_i);
    port_o[p] <= 1'b0;
    repeat (2) @(posedge clk_i);
    port_o[p] <= 1'b1;
  endtask : fall
  task automatic set_irq(input logic r, input logic e, input logic f);
    @(posedge clk_i);
    {irq_o, irq_en_o, full_o} <= {r, e, f};
  endtask : set_irq
endmodule : pdw_core_model

// *** pdw_ctrl.sv ***
// Power-down entry, wake-up sequencing and clock output control
`timescale 1ns/1ps
// Functional notes
// - Sleep entered only on halt instruction; oscillator stops, core halts there.
// - Memory and registers kept unchanged while asleep.
// - Watchdog cleared on sleep; runs on own oscillator, stops on system clock.
// - Port outputs and directions frozen during sleep.
// - Halt sets power-down flag and clears timeout flag.
// - Dedicated watchdog oscillator runs in sleep; may be disabled by option.
// - Wake on external reset, port A fall, interrupt or watchdog overflow.
// - External reset wake does a complete system reset.
// - Watchdog wake sets timeout flag, resets only PC and stack pointer.
// - Power-down flag cleared by power-up or watchdog clear, set by halt.
// - Each port A pin has its own wake enable option.
// - Port A wake resumes at instruction after halt.
// - Disabled or stack-full interrupt wake resumes after halt; request stays pending.
// - Enabled interrupt with free stack gets normal interrupt response.
// - Interrupt already pending at halt does not wake.
// - Every wake waits 1024 system clocks before running.
// - Interrupt wake delays service entry by at least one further cycle.
// - Instruction after halt runs right after the restart delay.
// - Option selects one clock source: crystal or resistor oscillator.
// - Resistor mode drives clock divided by 8 open-drain on second pin.
// - Watchdog timeout in normal run gives full reset and sets timeout flag.
module pdw_ctrl #(
  parameter int unsigned PORT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_exec_i,
  input wire logic wdt_clear_i,
  input wire logic wdt_overflow_i,
  input wire logic ext_reset_i,
  input wire logic [PORT_W-1:0] port_a_i,
  input wire logic irq_req_i,
  input wire logic irq_enabled_i,
  input wire logic stack_full_i,
  output logic osc_run_o,
  output logic core_stall_o,
  output logic io_freeze_o,
  output logic wdt_clear_o,
  output logic wdt_run_o,
  output logic pc_sp_reset_o,
  output logic full_reset_o,
  output logic irq_take_o,
  output logic power_down_flag_o,
  output logic watchdog_timeout_flag_o,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe_o
);
  typedef struct packed {
    pdw_pkg::pdw_state_e st;
    logic [10:0] cnt;
    pdw_pkg::pdw_cause_e cause;
    logic power_down_flag;
    logic tof;
    logic wdt_own_osc;
    logic wdt_osc_en;
    logic rc_mode;
    logic [PORT_W-1:0] wake_en;
    logic [PORT_W-1:0] port_q;
    logic irq_pend_at_halt;
    logic [2:0] div;
    logic div_out;
    logic pin_oe;
    pdw_pkg::pdw_wb_rsp_s wb;
    logic osc_run;
    logic stall;
    logic freeze;
    logic wdt_clr;
    logic wdt_run;
    logic pcsp;
    logic frst;
    logic irq_take;
  } pdw_ctrl_s;

  pdw_ctrl_s q;
  pdw_ctrl_s next_q;
  logic wb_req;
  logic [PORT_W-1:0] port_fall;

  assign wb_req = wb_cyc_i && wb_stb_i && !q.wb.ack;
  // Sampled edges stand in for the asynchronous capture of the real silicon
  assign port_fall = q.port_q & ~port_a_i & q.wake_en;

  always_comb begin
    next_q = q;
    next_q.port_q = port_a_i;
    next_q.wdt_clr = 1'b0;
    next_q.pcsp = 1'b0;
    next_q.frst = 1'b0;
    next_q.irq_take = 1'b0;
    next_q.wb.ack = wb_req;
    next_q.wb.dat = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        pdw_pkg::ADDR_CTRL: next_q.wb.dat = {29'h0000_0000, q.rc_mode, q.wdt_osc_en,
                                             q.wdt_own_osc};
        pdw_pkg::ADDR_STAT: next_q.wb.dat = {28'h000_0000, q.stall,
                                             q.st == pdw_pkg::PDW_SLEEP, q.tof, q.power_down_flag};
        pdw_pkg::ADDR_WAKE_EN: next_q.wb.dat = 32'(q.wake_en);
        pdw_pkg::ADDR_CAUSE: next_q.wb.dat = 32'(q.cause);
        default: next_q.wb.dat = 32'h0000_0000;
      endcase
    end
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      // Options writable in any state, asleep too; clock source is a single bit so one only
      if (wb_adr_i == pdw_pkg::ADDR_CTRL) begin
        next_q.wdt_own_osc = wb_dat_i[pdw_pkg::CTRL_WDT_OWN_OSC];
        next_q.wdt_osc_en = wb_dat_i[pdw_pkg::CTRL_WDT_OSC_EN];
        next_q.rc_mode = wb_dat_i[pdw_pkg::CTRL_RC_MODE];
      end
      if (wb_adr_i == pdw_pkg::ADDR_WAKE_EN) begin
        next_q.wake_en = wb_dat_i[PORT_W-1:0];
      end
    end
    // Divide by 8 output, open drain: enable only when pulling low
    if (q.rc_mode && q.osc_run) begin
      next_q.div = q.div + 3'h1;
      if (q.div == pdw_pkg::RC_DIV_LAST || q.div == 3'h7) begin
        next_q.div_out = ~q.div_out;
      end
    end
    // Registered so the pin never glitches on a mode change
    next_q.pin_oe = next_q.rc_mode & ~next_q.div_out;
    // Own oscillator, when enabled, keeps watchdog alive in sleep; system clock source or a disabled oscillator stops it
    next_q.wdt_run = q.st == pdw_pkg::PDW_SLEEP ? (q.wdt_own_osc && q.wdt_osc_en)
                                                : 1'b1;
    case (q.st)
      pdw_pkg::PDW_RUN: begin
        if (wdt_clear_i) begin
          next_q.power_down_flag = 1'b0;
        end
        if (wdt_overflow_i) begin
          next_q.tof = 1'b1;
          next_q.frst = 1'b1;
        end else if (halt_exec_i) begin
          next_q.st = pdw_pkg::PDW_SLEEP;
          next_q.power_down_flag = 1'b1;
          next_q.tof = 1'b0;
          next_q.wdt_clr = 1'b1;
          next_q.irq_pend_at_halt = irq_req_i;
          next_q.osc_run = 1'b0;
          next_q.stall = 1'b1;
          next_q.freeze = 1'b1;
          next_q.cause = pdw_pkg::PDW_WK_NONE;
        end
      end
      pdw_pkg::PDW_SLEEP: begin
        if (|port_fall) begin
          next_q.cause = pdw_pkg::PDW_WK_PORT;
        end else if (irq_req_i && !q.irq_pend_at_halt) begin
          next_q.cause = pdw_pkg::PDW_WK_IRQ;
        end else if (wdt_overflow_i && q.wdt_run) begin
          next_q.cause = pdw_pkg::PDW_WK_WDT;
          next_q.tof = 1'b1;
        end
        if (|port_fall || (irq_req_i && !q.irq_pend_at_halt) ||
            (wdt_overflow_i && q.wdt_run)) begin
          next_q.st = pdw_pkg::PDW_DELAY;
          next_q.osc_run = 1'b1;
          next_q.cnt = 11'h000;
        end
        if (!irq_req_i) begin
          next_q.irq_pend_at_halt = 1'b0;
        end
      end
      pdw_pkg::PDW_DELAY: begin
        next_q.cnt = q.cnt + 11'h001;
        if (q.cnt == pdw_pkg::RESTART_CNT - 11'h001) begin
          next_q.freeze = 1'b0;
          if (q.cause == pdw_pkg::PDW_WK_WDT) begin
            next_q.pcsp = 1'b1;
            next_q.stall = 1'b0;
            next_q.st = pdw_pkg::PDW_RUN;
          end else if (q.cause == pdw_pkg::PDW_WK_IRQ && irq_enabled_i && !stack_full_i) begin
            next_q.st = pdw_pkg::PDW_ISR;
          end else begin
            next_q.stall = 1'b0;
            next_q.st = pdw_pkg::PDW_RUN;
          end
        end
      end
      pdw_pkg::PDW_ISR: begin
        next_q.irq_take = 1'b1;
        next_q.stall = 1'b0;
        next_q.st = pdw_pkg::PDW_RUN;
      end
      pdw_pkg::PDW_RSTOUT: begin
        next_q.st = pdw_pkg::PDW_RUN;
      end
      default: next_q.st = pdw_pkg::PDW_RUN;
    endcase
    // External reset always wins; a wake from sleep still waits out the restart delay
    if (ext_reset_i) begin
      next_q.frst = 1'b1;
      next_q.osc_run = 1'b1;
      next_q.freeze = 1'b0;
      next_q.wdt_clr = 1'b1;
      next_q.pcsp = 1'b0;
      next_q.irq_take = 1'b0;
      next_q.cause = pdw_pkg::PDW_WK_NONE;
      if (q.stall) begin
        next_q.st = pdw_pkg::PDW_DELAY;
        next_q.cnt = 11'h000;
        next_q.stall = 1'b1;
      end else begin
        next_q.st = pdw_pkg::PDW_RSTOUT;
        next_q.stall = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= pdw_pkg::PDW_RUN;
      q.cause <= pdw_pkg::PDW_WK_NONE;
      q.osc_run <= 1'b1;
      q.wdt_run <= 1'b1;
      q.wdt_own_osc <= 1'b1;
      q.wdt_osc_en <= 1'b1;
      q.wake_en <= PORT_W'(pdw_pkg::WAKE_EN_RST);
      q.port_q <= '1;
      q.frst <= 1'b1; // Power-up clears both flags and resets all
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.wb.dat;
  assign wb_ack_o = q.wb.ack;
  assign osc_run_o = q.osc_run;
  assign core_stall_o = q.stall;
  assign io_freeze_o = q.freeze;
  assign wdt_clear_o = q.wdt_clr;
  assign wdt_run_o = q.wdt_run;
  assign pc_sp_reset_o = q.pcsp;
  assign full_reset_o = q.frst;
  assign irq_take_o = q.irq_take;
  assign power_down_flag_o = q.power_down_flag;
  assign watchdog_timeout_flag_o = q.tof;
  assign osc_output_pin_o = 1'b0;
  assign osc_output_pin_oe_o = q.pin_oe;
endmodule : pdw_ctrl

// *** pdw_ctrl_monitor.sv ***
// Checker for the power-down and wake-up controller
`timescale 1ns/1ps
module pdw_ctrl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_exec_i,
  input wire logic wdt_clear_i,
  input wire logic wdt_overflow_i,
  input wire logic ext_reset_i,
  input wire logic osc_run_o,
  input wire logic core_stall_o,
  input wire logic io_freeze_o,
  input wire logic wdt_clear_o,
  input wire logic wdt_run_o,
  input wire logic pc_sp_reset_o,
  input wire logic full_reset_o,
  input wire logic irq_take_o,
  input wire logic power_down_flag_o,
  input wire logic watchdog_timeout_flag_o
);
  logic [11:0] cnt;
  logic go;
  // Overflow wins over a simultaneous halt
  assign go = halt_exec_i && !core_stall_o && !wdt_overflow_i && !ext_reset_i;
  always_ff @(posedge clk_i) begin
    cnt <= (rst_i || ext_reset_i || !(core_stall_o && osc_run_o)) ? 12'h000 : cnt + 12'h001;
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  halt_stop_a: assert property (go |=> core_stall_o && !osc_run_o && wdt_clear_o)
    else $error("halt entry");
  halt_flags_a: assert property (go |=> power_down_flag_o && !watchdog_timeout_flag_o)
    else $error("halt flags");
  sleep_hold_a: assert property (core_stall_o && !osc_run_o |-> io_freeze_o)
    else $error("freeze");
  restart_len_a: assert property ($fell(core_stall_o) |->
    (cnt == 12'h400 && !irq_take_o) || (cnt == 12'h401 && irq_take_o))
    else $error("restart delay");
  isr_late_a: assert property (irq_take_o |->
    !core_stall_o && $past(core_stall_o) && cnt == 12'h401)
    else $error("isr entry");
  wdt_wake_a: assert property (core_stall_o && !osc_run_o && wdt_overflow_i && wdt_run_o
    |=> watchdog_timeout_flag_o && power_down_flag_o) else $error("wdt wake");
  run_timeout_a: assert property (wdt_overflow_i && !core_stall_o
    |=> full_reset_o && watchdog_timeout_flag_o) else $error("run timeout");
  ext_reset_a: assert property (ext_reset_i |=> full_reset_o)
    else $error("ext reset");
  pdf_clear_a: assert property (wdt_clear_i && !halt_exec_i |=> !power_down_flag_o)
    else $error("pdf clear");
  cover property (irq_take_o);
  cover property (pc_sp_reset_o);
  cover property ($fell(core_stall_o));
endmodule : pdw_ctrl_monitor
bind pdw_ctrl pdw_ctrl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .halt_exec_i(halt_exec_i),
  .wdt_clear_i(wdt_clear_i), .wdt_overflow_i(wdt_overflow_i), .ext_reset_i(ext_reset_i),
  .osc_run_o(osc_run_o), .core_stall_o(core_stall_o), .io_freeze_o(io_freeze_o),
  .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o), .pc_sp_reset_o(pc_sp_reset_o),
  .full_reset_o(full_reset_o), .irq_take_o(irq_take_o),
  .power_down_flag_o(power_down_flag_o), .watchdog_timeout_flag_o(watchdog_timeout_flag_o));

// *** pdw_pkg.sv ***
// Package for the power-down and wake-up controller
package pdw_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RESTART_CLKS = 1024;
  localparam logic [10:0] RESTART_CNT = 11'h0400;
  localparam int unsigned ISR_EXTRA = 1;
  localparam logic [2:0] RC_DIV_LAST = 3'h3;

  // Wishbone word addresses (byte offsets)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
  localparam logic [7:0] ADDR_CAUSE = 8'h0C;

  // CTRL fields
  localparam int unsigned CTRL_WDT_OWN_OSC = 0;
  localparam int unsigned CTRL_WDT_OSC_EN = 1;
  localparam int unsigned CTRL_RC_MODE = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;

  // STAT fields
  localparam int unsigned STAT_PDF = 0;
  localparam int unsigned STAT_TO = 1;
  localparam int unsigned STAT_ASLEEP = 2;
  localparam int unsigned STAT_STALL = 3;

  localparam logic [7:0] WAKE_EN_RST = 8'h00;

  typedef enum logic [4:0] {
    PDW_RUN = 5'b00001,
    PDW_SLEEP = 5'b00010,
    PDW_DELAY = 5'b00100,
    PDW_ISR = 5'b01000,
    PDW_RSTOUT = 5'b10000
  } pdw_state_e;

  typedef enum logic [1:0] {
    PDW_WK_NONE = 2'h0,
    PDW_WK_PORT = 2'h1,
    PDW_WK_IRQ = 2'h2,
    PDW_WK_WDT = 2'h3
  } pdw_cause_e;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } pdw_wb_rsp_s;
endpackage : pdw_pkg

// *** tb_power_down_wakeup_control.sv ***
// Bench for the power-down and wake-up controller
`timescale 1ns/1ps
module tb_power_down_wakeup_control;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, halt_exec_i, wdt_clear_i;
  logic wdt_overflow_i, ext_reset_i, irq_req_i, irq_enabled_i, stack_full_i, osc_run_o;
  logic core_stall_o, io_freeze_o, wdt_clear_o, wdt_run_o, pc_sp_reset_o, full_reset_o;
  logic irq_take_o, power_down_flag_o, watchdog_timeout_flag_o, osc_output_pin_o;
  logic osc_output_pin_oe_o, pin, t;
  logic [7:0] wb_adr_i, port_a_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  int fails = 0, n_compared = 0, cyc = 0, n;
  pdw_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halt_exec_i(halt_exec_i),
    .wdt_clear_i(wdt_clear_i), .wdt_overflow_i(wdt_overflow_i), .ext_reset_i(ext_reset_i),
    .port_a_i(port_a_i), .irq_req_i(irq_req_i), .irq_enabled_i(irq_enabled_i),
    .stack_full_i(stack_full_i), .osc_run_o(osc_run_o), .core_stall_o(core_stall_o),
    .io_freeze_o(io_freeze_o), .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o),
    .pc_sp_reset_o(pc_sp_reset_o), .full_reset_o(full_reset_o), .irq_take_o(irq_take_o),
    .power_down_flag_o(power_down_flag_o), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
    .osc_output_pin_o(osc_output_pin_o), .osc_output_pin_oe_o(osc_output_pin_oe_o));
  pdw_core_model core (.clk_i(clk_i), .pin_oe_i(osc_output_pin_oe_o), .halt_o(halt_exec_i),
    .clr_o(wdt_clear_i), .ovf_o(wdt_overflow_i), .ext_o(ext_reset_i), .port_o(port_a_i),
    .irq_o(irq_req_i), .irq_en_o(irq_enabled_i), .full_o(stack_full_i), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic wait_run();
    n = 0;
    while (core_stall_o !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_run
  task automatic t_port();
    wb(1'b1, pdw_pkg::ADDR_WAKE_EN, 32'h2);
    wb(1'b0, pdw_pkg::ADDR_WAKE_EN, 32'h0);
    chk("wake enable", 32'h2, rd);
    core.pulse(0);
    chk("sleep", 32'h35, {core_stall_o, power_down_flag_o, watchdog_timeout_flag_o,
      io_freeze_o, osc_run_o, wdt_run_o});
    wb(1'b0, pdw_pkg::ADDR_STAT, 32'h0);
    chk("status", 32'hD, rd);
    core.fall(1);
    wait_run();
    chk("delay", 32'h1, n > 1018 && n < 1027);
    wb(1'b0, pdw_pkg::ADDR_CAUSE, 32'h0);
    chk("port cause", 32'h1, rd);
    core.pulse(1);
    chk("pdf", 32'h0, power_down_flag_o);
  endtask : t_port
  task automatic t_wdt();
    core.pulse(0);
    core.pulse(2);
    chk("wdt flags", 32'h3, {watchdog_timeout_flag_o, power_down_flag_o});
    wait_run();
    while (pc_sp_reset_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk("pc sp", 32'h2, {pc_sp_reset_o, full_reset_o});
    wb(1'b0, pdw_pkg::ADDR_CAUSE, 32'h0);
    chk("wdt cause", 32'h3, rd);
    core.pulse(2);
    chk("run timeout", 32'h3, {full_reset_o, watchdog_timeout_flag_o});
  endtask : t_wdt
  task automatic t_irq();
    // Enabled, disabled, then enabled with a full stack
    for (int k = 0; k < 3; k++) begin
      core.set_irq(1'b0, k != 1, k == 2);
      core.pulse(0);
      core.set_irq(1'b1, k != 1, k == 2);
      wait_run();
      t = irq_take_o;
      repeat (3) @(posedge clk_i) t |= irq_take_o;
      chk("isr", k == 0, t);
      core.set_irq(1'b0, 1'b0, 1'b0);
    end
  endtask : t_irq
  task automatic t_pend();
    core.set_irq(1'b1, 1'b1, 1'b0);
    core.pulse(0);
    repeat (20) @(posedge clk_i);
    chk("pending", 32'h2, {core_stall_o, osc_run_o});
    core.pulse(3);
    chk("ext reset", 32'h1, full_reset_o);
    core.set_irq(1'b0, 1'b0, 1'b0);
    wait_run();
    chk("ext delay", 32'h1, n > 1018 && n < 1027);
  endtask : t_pend
  task automatic t_wdt_off();
    // Watchdog on the system clock, or with its oscillator off, cannot wake
    for (int m = 1; m < 3; m++) begin
      wb(1'b1, pdw_pkg::ADDR_CTRL, 32'(m));
      core.pulse(0);
      core.pulse(2);
      chk("wdt stopped", 32'h8, {core_stall_o, osc_run_o, wdt_run_o,
        watchdog_timeout_flag_o});
      core.fall(1);
      wait_run();
      chk("port wake", 32'h1, n > 1018 && n < 1027);
    end
    wb(1'b1, pdw_pkg::ADDR_CTRL, 32'h3);
  endtask : t_wdt_off
  task automatic t_rc();
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, pdw_pkg::ADDR_CTRL, {29'h0, m[0], 2'b11});
      n = 0;
      t = pin;
      repeat (32) begin
        @(posedge clk_i);
        n += (pin !== t);
        t = pin;
      end
      chk("clock out", m * 8, n);
      chk("pin data", 32'h0, osc_output_pin_o);
    end
  endtask : t_rc
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 40'h0};
    wb_sel_i = 4'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, pdw_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h3, rd);
    wb(1'b1, 8'h10, 32'hFF);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb_sel_i <= 4'hE;
    wb(1'b1, pdw_pkg::ADDR_WAKE_EN, 32'hFF);
    wb_sel_i <= 4'h1;
    wb(1'b0, pdw_pkg::ADDR_WAKE_EN, 32'h0);
    chk("lane 0 only", 32'h0, rd);
    t_port();
    t_wdt();
    t_irq();
    t_pend();
    t_wdt_off();
    t_rc();
    end_of_test();
  end
endmodule : tb_power_down_wakeup_control
